//--- asr_pkg.sv
// What this block does
// - each converter has own serial input; any input may feed any converter
// - the input feeding converter one also feeds S/PDIF and secondary senders
// - converters two and three take only primary receiver data
// - bits 8:7 pick converter one source; 00 may switch converters 2-3 off
// - bits 8:7 pick primary sender source: S/PDIF, ADC or secondary data
// - bits 8:7 pick secondary sender source: S/PDIF, ADC or primary data
// - bits 1:0 pick S/PDIF payload source among all four streams
// - bit 3 drives the S/PDIF pin from the input mux instead
// - each block clock is chosen from up to four clock sources
// - S/PDIF data on converter one forces that path's clock choice
// - register 8 bits 1:0 program the converter clock
// - effective converter clock select mixes programmed field and routing
// - effective ADC clock select mixes programmed field and routing
// - PLL clock sources are the divided PLL outputs
// - converter clock is system clock or a PLL; S/PDIF routing forces PLL A
// - register 8 bits 3:2 program the ADC clock before any override
// - register 6 bit 6 set disables automatic clock choice
package asr_pkg;
	localparam int SMP_W = 48;
	localparam int IDX_W = 8;
	localparam logic [IDX_W-1:0] IDX_OVERRIDE = 8'h06;
	localparam logic [IDX_W-1:0] IDX_CLK_SEL = 8'h08;
	localparam logic [IDX_W-1:0] IDX_DAC1_SRC = 8'h0C;
	localparam logic [IDX_W-1:0] IDX_PTX_SRC = 8'h0D;
	localparam logic [IDX_W-1:0] IDX_STX_SRC = 8'h0E;
	localparam logic [IDX_W-1:0] IDX_SPTX_SRC = 8'h1E;
	localparam logic [IDX_W-1:0] IDX_PRI_MAP = 8'h20;
	localparam int IDX_LSB = 2;
	localparam int ROUTE_LSB = 7;
	localparam int PAYLOAD_LSB = 0;
	localparam int THROUGH_BIT = 3;
	localparam int DAC_CLK_LSB = 0;
	localparam int ADC_CLK_LSB = 2;
	localparam int MANUAL_BIT = 6;
	localparam int MAP_LSB = 0;
	localparam int RATE_MODE_BIT = 8;
	localparam logic [1:0] SRC_SPDIF = 2'h0;
	localparam logic [1:0] SRC_ADC = 2'h1;
	localparam logic [1:0] SRC_SEC = 2'h2;
	localparam logic [1:0] SRC_PRI = 2'h3;
	localparam logic [3:0] OK_DAC1 = 4'hD;
	localparam logic [3:0] OK_PTX = 4'h7;
	localparam logic [3:0] OK_STX = 4'hB;
	localparam logic [3:0] OK_SPTX = 4'hF;
	localparam logic [1:0] RST_DAC1_SRC = SRC_PRI;
	localparam logic [1:0] RST_PTX_SRC = SRC_ADC;
	localparam logic [1:0] RST_STX_SRC = SRC_SPDIF;
	localparam logic [1:0] RST_SPTX_SRC = SRC_SPDIF;
	localparam logic RST_THROUGH = 1'b0;
	localparam logic RST_MANUAL = 1'b0;
	localparam logic RST_RATE_MODE = 1'b0;
	localparam logic [1:0] RST_DAC_CLK = 2'h0;
	localparam logic [1:0] RST_ADC_CLK = 2'h0;
	localparam logic [5:0] RST_PRI_MAP = 6'h24;
	// clock source codes; both PLL codes mean the post-divider outputs
	localparam logic [1:0] CLK_MCLK = 2'h0;
	localparam logic [1:0] CLK_ADC_MCLK = 2'h1;
	localparam logic [1:0] CLK_PLLA = 2'h2;
	localparam logic [1:0] CLK_PLLB = 2'h3;
	localparam logic [1:0] DACF_MCLK = 2'h0;
	localparam logic [1:0] DACF_PLLA = 2'h1;
	localparam logic [1:0] DACF_PLLB = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- asr_buf2.sv
module asr_buf2 #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [W-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	typedef struct packed {
		logic [1:0][W-1:0] mem;
		logic wp;
		logic rp;
		logic [1:0] cnt;
	} asr_buf_t;
	asr_buf_t s_reg;
	asr_buf_t s_next;
	logic push;
	logic pop;

	assign in_ready = (s_reg.cnt != 2'h2);
	assign out_valid = (s_reg.cnt != 2'h0);
	assign out_data = s_reg.mem[s_reg.rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		s_next = s_reg;
		if (push) begin
			s_next.mem[s_reg.wp] = in_data;
			s_next.wp = ~s_reg.wp;
		end
		if (pop) begin
			s_next.rp = ~s_reg.rp;
		end
		if (push && !pop) begin
			s_next.cnt = s_reg.cnt + 2'h1;
		end else if (pop && !push) begin
			s_next.cnt = s_reg.cnt - 2'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
endmodule

//--- asr_router.sv
// Our own choice: the AXI4-Lite interface to the registers.
module asr_router
	import asr_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [2:0][SMP_W-1:0] converter_serial_inputs,
	input wire logic [2:0] converter_serial_valid,
	input wire logic [SMP_W-1:0] spdif_rx_data,
	input wire logic spdif_rx_valid,
	input wire logic [SMP_W-1:0] adc_data,
	input wire logic adc_valid,
	input wire logic [SMP_W-1:0] sec_rx_data,
	input wire logic sec_rx_valid,
	output logic [2:0][SMP_W-1:0] dac_data,
	output logic [2:0] dac_valid,
	output logic [2:0] dac_enable,
	output logic [SMP_W-1:0] pri_tx_data,
	output logic pri_tx_valid,
	output logic [SMP_W-1:0] sec_tx_data,
	output logic sec_tx_valid,
	output logic [SMP_W-1:0] spdif_tx_data,
	output logic spdif_tx_valid,
	input wire logic spdif_tx_ready,
	output logic spdif_payload_src_ready,
	input wire logic spdif_in_mux_bit,
	input wire logic spdif_tx_coded_bit,
	output logic spdif_output_pin,
	output logic [1:0] dac_clk_src,
	output logic [1:0] adc_clk_src
);
	typedef logic [SMP_W:0] asr_word_t;
	typedef struct packed {
		logic [1:0] dac1_src;
		logic [1:0] ptx_src;
		logic [1:0] stx_src;
		logic [1:0] sptx_src;
		logic through;
		logic manual;
		logic rate_mode;
		logic [1:0] dac_clk_fld;
		logic [1:0] adc_clk_fld;
		logic [5:0] pri_map;
		logic [2:0][SMP_W-1:0] dac_d;
		logic [2:0] dac_v;
		logic [2:0] dac_en;
		logic [SMP_W-1:0] ptx_d;
		logic ptx_v;
		logic [SMP_W-1:0] stx_d;
		logic stx_v;
		logic pin;
		logic [1:0] dac_clk;
		logic [1:0] adc_clk;
		logic aw_held;
		logic [IDX_W-1:0] aw_idx;
		logic w_held;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} asr_state_t;

	asr_state_t s_reg;
	asr_state_t s_next;
	asr_word_t [2:0] slot;
	asr_word_t [3:0] srcs;
	asr_word_t sptx_pick;
	logic sptx_in_ready;

	// primary receiver muxes: any serial input to any converter
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_slot
			logic [1:0] sel;
			assign sel = s_reg.pri_map[MAP_LSB+2*gi +: 2];
			// select code 3 is reserved: that slot reads as silence
			assign slot[gi] = (sel < 2'h3)
				? {converter_serial_valid[sel],
				converter_serial_inputs[sel]}
				: '0;
		end
	endgenerate

	// the slot feeding converter one is the primary stream for other senders
	assign srcs[SRC_SPDIF] = {spdif_rx_valid, spdif_rx_data};
	assign srcs[SRC_ADC] = {adc_valid, adc_data};
	assign srcs[SRC_SEC] = {sec_rx_valid, sec_rx_data};
	assign srcs[SRC_PRI] = slot[0];

	function automatic asr_word_t pick(input logic [1:0] code,
		input logic [3:0] ok);
		pick = ok[code] ? srcs[code] : '0;
	endfunction

	function automatic logic mapped(input logic [IDX_W-1:0] idx);
		case (idx)
			IDX_OVERRIDE, IDX_CLK_SEL, IDX_DAC1_SRC, IDX_PTX_SRC,
			IDX_STX_SRC, IDX_SPTX_SRC, IDX_PRI_MAP: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	endfunction

	function automatic logic [31:0] reg_word(input asr_state_t st,
		input logic [IDX_W-1:0] idx);
		logic [31:0] w;
		w = '0;
		case (idx)
			IDX_OVERRIDE: w[MANUAL_BIT] = st.manual;
			IDX_CLK_SEL: begin
				w[DAC_CLK_LSB +: 2] = st.dac_clk_fld;
				w[ADC_CLK_LSB +: 2] = st.adc_clk_fld;
			end
			IDX_DAC1_SRC: w[ROUTE_LSB +: 2] = st.dac1_src;
			IDX_PTX_SRC: w[ROUTE_LSB +: 2] = st.ptx_src;
			IDX_STX_SRC: w[ROUTE_LSB +: 2] = st.stx_src;
			IDX_SPTX_SRC: begin
				w[PAYLOAD_LSB +: 2] = st.sptx_src;
				w[THROUGH_BIT] = st.through;
			end
			IDX_PRI_MAP: begin
				w[MAP_LSB +: 6] = st.pri_map;
				w[RATE_MODE_BIT] = st.rate_mode;
			end
			default: w = '0;
		endcase
		reg_word = w;
	endfunction

	// two-word payload buffer: a stalled transmitter loses only the samples that arrive once it is full
	// a plain assign would not wake on the streams that pick reads
	always_comb begin
		sptx_pick = pick(s_reg.sptx_src, OK_SPTX);
	end

	asr_buf2 #(
		.W(SMP_W)
	) u_sptx_buf (
		.clk(clk),
		.rst_n(rst_n),
		.in_data(sptx_pick[SMP_W-1:0]),
		.in_valid(sptx_pick[SMP_W]),
		.in_ready(sptx_in_ready),
		.out_data(spdif_tx_data),
		.out_valid(spdif_tx_valid),
		.out_ready(spdif_tx_ready)
	);
	assign spdif_payload_src_ready = sptx_in_ready;

	assign s_axi_awready = !s_reg.aw_held && !s_reg.bvalid;
	assign s_axi_wready = !s_reg.w_held && !s_reg.bvalid;
	assign s_axi_bvalid = s_reg.bvalid;
	assign s_axi_bresp = s_reg.bresp;
	assign s_axi_arready = !s_reg.rvalid;
	assign s_axi_rvalid = s_reg.rvalid;
	assign s_axi_rdata = s_reg.rdata;
	assign s_axi_rresp = s_reg.rresp;
	assign dac_data = s_reg.dac_d;
	assign dac_valid = s_reg.dac_v;
	assign dac_enable = s_reg.dac_en;
	assign pri_tx_data = s_reg.ptx_d;
	assign pri_tx_valid = s_reg.ptx_v;
	assign sec_tx_data = s_reg.stx_d;
	assign sec_tx_valid = s_reg.stx_v;
	assign spdif_output_pin = s_reg.pin;
	assign dac_clk_src = s_reg.dac_clk;
	assign adc_clk_src = s_reg.adc_clk;

	always_comb begin
		asr_word_t p;
		logic [31:0] mask;
		logic [31:0] mrg;
		logic [IDX_W-1:0] ridx;
		logic spdif_dac1;
		logic rx_shared;
		p = '0;
		mask = '0;
		mrg = '0;
		ridx = s_axi_araddr[IDX_LSB +: IDX_W];
		// every local gets a value before any branch reads it
		spdif_dac1 = 1'b0;
		rx_shared = 1'b0;
		s_next = s_reg;

		// bus: address and data taken in either order, then answered
		if (s_axi_awvalid && s_axi_awready) begin
			s_next.aw_held = 1'b1;
			s_next.aw_idx = s_axi_awaddr[IDX_LSB +: IDX_W];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_next.w_held = 1'b1;
			s_next.wdata = s_axi_wdata;
			s_next.wstrb = s_axi_wstrb;
		end
		if (s_reg.bvalid && s_axi_bready) begin
			s_next.bvalid = 1'b0;
		end
		if (s_reg.aw_held && s_reg.w_held) begin
			for (int b = 0; b < 4; b++) begin
				mask[8*b +: 8] = {8{s_reg.wstrb[b]}};
			end
			mrg = (reg_word(s_reg, s_reg.aw_idx) & ~mask)
				| (s_reg.wdata & mask);
			case (s_reg.aw_idx)
				IDX_OVERRIDE: s_next.manual = mrg[MANUAL_BIT];
				IDX_CLK_SEL: begin
					s_next.dac_clk_fld = mrg[DAC_CLK_LSB +: 2];
					s_next.adc_clk_fld = mrg[ADC_CLK_LSB +: 2];
				end
				IDX_DAC1_SRC: s_next.dac1_src = mrg[ROUTE_LSB +: 2];
				IDX_PTX_SRC: s_next.ptx_src = mrg[ROUTE_LSB +: 2];
				IDX_STX_SRC: s_next.stx_src = mrg[ROUTE_LSB +: 2];
				IDX_SPTX_SRC: begin
					s_next.sptx_src = mrg[PAYLOAD_LSB +: 2];
					s_next.through = mrg[THROUGH_BIT];
				end
				IDX_PRI_MAP: begin
					s_next.pri_map = mrg[MAP_LSB +: 6];
					s_next.rate_mode = mrg[RATE_MODE_BIT];
				end
				default: begin
				end
			endcase
			s_next.aw_held = 1'b0;
			s_next.w_held = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = mapped(s_reg.aw_idx) ? RESP_OKAY : RESP_SLVERR;
		end

		if (s_reg.rvalid && s_axi_rready) begin
			s_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			s_next.rvalid = 1'b1;
			s_next.rdata = reg_word(s_reg, ridx);
			s_next.rresp = mapped(ridx) ? RESP_OKAY : RESP_SLVERR;
		end

		// converter one: S/PDIF, secondary or primary; 01 is reserved
		spdif_dac1 = (s_reg.dac1_src == SRC_SPDIF);
		p = pick(s_reg.dac1_src, OK_DAC1);
		s_next.dac_v[0] = p[SMP_W];
		if (!OK_DAC1[s_reg.dac1_src]) begin
			s_next.dac_d[0] = '0;
		end else if (p[SMP_W]) begin
			s_next.dac_d[0] = p[SMP_W-1:0];
		end

		// converters two and three stay on primary data only
		rx_shared = spdif_dac1 && !s_reg.rate_mode;
		s_next.dac_en = {!rx_shared, !rx_shared, 1'b1};
		for (int k = 1; k < 3; k++) begin
			s_next.dac_v[k] = slot[k][SMP_W] && !rx_shared;
			if (rx_shared) begin
				s_next.dac_d[k] = '0;
			end else if (slot[k][SMP_W]) begin
				s_next.dac_d[k] = slot[k][SMP_W-1:0];
			end
		end

		p = pick(s_reg.ptx_src, OK_PTX);
		s_next.ptx_v = p[SMP_W];
		if (!OK_PTX[s_reg.ptx_src]) begin
			s_next.ptx_d = '0;
		end else if (p[SMP_W]) begin
			s_next.ptx_d = p[SMP_W-1:0];
		end

		p = pick(s_reg.stx_src, OK_STX);
		s_next.stx_v = p[SMP_W];
		if (!OK_STX[s_reg.stx_src]) begin
			s_next.stx_d = '0;
		end else if (p[SMP_W]) begin
			s_next.stx_d = p[SMP_W-1:0];
		end

		s_next.pin = s_reg.through ? spdif_in_mux_bit
			: spdif_tx_coded_bit;

		// converter clock offers system clock and both divided PLLs only
		case (s_reg.dac_clk_fld)
			DACF_PLLA: s_next.dac_clk = CLK_PLLA;
			DACF_PLLB: s_next.dac_clk = CLK_PLLB;
			DACF_MCLK: s_next.dac_clk = CLK_MCLK;
			default: s_next.dac_clk = CLK_MCLK;
		endcase
		if (!s_reg.manual && spdif_dac1) begin
			s_next.dac_clk = CLK_PLLA;
		end

		// ADC may use all four; PLL A is yielded to the receiver path
		s_next.adc_clk = s_reg.adc_clk_fld;
		if (!s_reg.manual && spdif_dac1
			&& s_reg.adc_clk_fld == CLK_PLLA) begin
			s_next.adc_clk = CLK_MCLK;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_reg <= '0;
			s_reg.dac1_src <= RST_DAC1_SRC;
			s_reg.ptx_src <= RST_PTX_SRC;
			s_reg.stx_src <= RST_STX_SRC;
			s_reg.sptx_src <= RST_SPTX_SRC;
			s_reg.through <= RST_THROUGH;
			s_reg.manual <= RST_MANUAL;
			s_reg.rate_mode <= RST_RATE_MODE;
			s_reg.dac_clk_fld <= RST_DAC_CLK;
			s_reg.adc_clk_fld <= RST_ADC_CLK;
			s_reg.pri_map <= RST_PRI_MAP;
			s_reg.dac_en <= '1;
			s_reg.dac_clk <= CLK_MCLK;
			s_reg.adc_clk <= CLK_MCLK;
			s_reg.bresp <= RESP_OKAY;
			s_reg.rresp <= RESP_OKAY;
		end else begin
			s_reg <= s_next;
		end
	end
endmodule

//--- asr_router_asserts.sv
module asr_router_asserts
	import asr_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_arready,
	input wire logic [SMP_W-1:0] adc_data,
	input wire logic adc_valid,
	input wire logic spdif_rx_valid,
	input wire logic sec_rx_valid,
	input wire logic [2:0] converter_serial_valid,
	input wire logic [2:0][SMP_W-1:0] dac_data,
	input wire logic [2:0] dac_valid,
	input wire logic [2:0] dac_enable,
	input wire logic [SMP_W-1:0] pri_tx_data,
	input wire logic pri_tx_valid,
	input wire logic [SMP_W-1:0] spdif_tx_data,
	input wire logic spdif_tx_valid,
	input wire logic spdif_tx_ready,
	input wire logic spdif_payload_src_ready,
	input wire logic [1:0] dac_clk_src
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	property p_pair_en;
		dac_enable[1] == dac_enable[2] && dac_enable[0];
	endproperty
	a_pair_en: assert property (p_pair_en) else $error("enables split");
	property p_off_quiet;
		$past(!dac_enable[1]) && !dac_enable[1] |->
			dac_valid[2:1] == 2'h0 && dac_data[1] == '0 && dac_data[2] == '0;
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("off but busy");
	property p_dac_cause;
		dac_valid[2:1] != 2'h0 |-> $past(converter_serial_valid) != 3'h0;
	endproperty
	a_dac_cause: assert property (p_dac_cause) else $error("stray sample");
	property p_pri_adc;
		$past(adc_valid) && !$past(spdif_rx_valid || sec_rx_valid) &&
			pri_tx_valid |-> pri_tx_data == $past(adc_data);
	endproperty
	a_pri_adc: assert property (p_pri_adc) else $error("adc word bad");
	property p_dac_clk;
		dac_clk_src != CLK_ADC_MCLK;
	endproperty
	a_dac_clk: assert property (p_dac_clk) else $error("bad dac clock");
	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("read overlap");
	property p_tx_hold;
		spdif_tx_valid && !spdif_tx_ready |=>
			spdif_tx_valid && $stable(spdif_tx_data);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("word lost");
	property p_full;
		!spdif_payload_src_ready |-> spdif_tx_valid;
	endproperty
	a_full: assert property (p_full) else $error("full yet empty");
	c_drop: cover property (spdif_rx_valid && !spdif_payload_src_ready);
	c_off: cover property (!dac_enable[1]);
	c_pll: cover property (dac_clk_src == CLK_PLLA);
endmodule

//--- asr_dsp_model.sv
module asr_dsp_model
	import asr_pkg::*;
(
	input wire logic clk,
	input wire logic [5:0] fire,
	input wire logic [SMP_W-1:0] word,
	input wire logic stall,
	output logic [SMP_W-1:0] spdif_rx_data,
	output logic spdif_rx_valid,
	output logic [SMP_W-1:0] adc_data,
	output logic adc_valid,
	output logic [SMP_W-1:0] sec_rx_data,
	output logic sec_rx_valid,
	output logic [2:0][SMP_W-1:0] converter_serial_inputs,
	output logic [2:0] converter_serial_valid,
	output logic spdif_tx_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{spdif_rx_data, adc_data, sec_rx_data} = '0;
		{spdif_rx_valid, adc_valid, sec_rx_valid} = '0;
		converter_serial_inputs = '0;
		converter_serial_valid = '0;
		spdif_tx_ready = 1'b1;
	end
	// idle lines toggle so a stale word never passes for a fresh sample
	always @(posedge clk) begin
		{sec_rx_valid, adc_valid, spdif_rx_valid} <= fire[2:0];
		converter_serial_valid <= fire[5:3];
		spdif_rx_data <= fire[0] ? word : ~spdif_rx_data;
		adc_data <= fire[1] ? word : ~adc_data;
		sec_rx_data <= fire[2] ? word : ~sec_rx_data;
		for (int i = 0; i < 3; i++) begin
			converter_serial_inputs[i] <= fire[3+i] ?
				word ^ SMP_W'(i) : ~converter_serial_inputs[i];
		end
		spdif_tx_ready <= !stall;
	end
endmodule

//--- test_asr_router.sv
`define CHK(g, e) \
	begin \
		comparisons++; \
		if ((g) !== (e)) begin \
			n_fail++; \
			$display("wrong value at %0t: %h vs %h", $time, g, e); \
		end \
	end
module test_asr_router
	import asr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [11:0] s_axi_awaddr = '0;
	logic [11:0] s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_bready = 1'b1;
	logic s_axi_rready = 1'b1;
	logic spdif_in_mux_bit = 1'b0;
	logic spdif_tx_coded_bit = 1'b0;
	logic [5:0] fire = '0;
	logic [SMP_W-1:0] word = '0;
	logic stall = 1'b0;
	logic [1:0] probe = '0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, dac_clk_src, adc_clk_src;
	logic [31:0] s_axi_rdata;
	logic [2:0][SMP_W-1:0] converter_serial_inputs, dac_data;
	logic [2:0] converter_serial_valid, dac_valid, dac_enable;
	logic [SMP_W-1:0] spdif_rx_data, adc_data, sec_rx_data;
	logic [SMP_W-1:0] pri_tx_data, sec_tx_data, spdif_tx_data;
	logic spdif_rx_valid, adc_valid, sec_rx_valid, pri_tx_valid;
	logic sec_tx_valid, spdif_tx_valid, spdif_tx_ready;
	logic spdif_payload_src_ready, spdif_output_pin;
	logic [SMP_W-1:0] exp [10][$];
	logic [1:0] src_m [4] = '{2'h3, 2'h1, 2'h0, 2'h0};
	logic [8:0] map_m = 9'h024;
	int n_fail = 0;
	int comparisons = 0;
	int cyc = 0;
	asr_router u_asr_router (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .converter_serial_inputs,
		.converter_serial_valid, .spdif_rx_data, .spdif_rx_valid, .adc_data,
		.adc_valid, .sec_rx_data, .sec_rx_valid, .dac_data, .dac_valid,
		.dac_enable, .pri_tx_data, .pri_tx_valid, .sec_tx_data, .sec_tx_valid,
		.spdif_tx_data, .spdif_tx_valid, .spdif_tx_ready,
		.spdif_payload_src_ready, .spdif_in_mux_bit, .spdif_tx_coded_bit,
		.spdif_output_pin, .dac_clk_src, .adc_clk_src);
	asr_dsp_model u_asr_dsp_model (.clk, .fire, .word, .stall,
		.spdif_rx_data, .spdif_rx_valid, .adc_data, .adc_valid, .sec_rx_data,
		.sec_rx_valid, .converter_serial_inputs, .converter_serial_valid,
		.spdif_tx_ready);
	always #5 clk = ~clk;
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			results();
		end
	end
	task automatic chk(input int id, input logic [SMP_W-1:0] got);
		logic [SMP_W-1:0] e;
		e = '0;
		`CHK(exp[id].size() != 0, 1'b1)
		if (exp[id].size() != 0)
			e = exp[id].pop_front();
		`CHK(got, e)
	endtask
	// an output with no pending note counts as a mismatch
	always @(posedge clk) begin
		for (int i = 0; i < 3; i++)
			if (dac_valid[i]) chk(i, dac_data[i]);
		if (pri_tx_valid) chk(3, pri_tx_data);
		if (sec_tx_valid) chk(4, sec_tx_data);
		if (spdif_tx_valid && spdif_tx_ready) chk(5, spdif_tx_data);
		if (probe[0]) chk(6, SMP_W'(spdif_output_pin));
		if (probe[1]) chk(7, SMP_W'({dac_clk_src, adc_clk_src}));
		if (s_axi_rvalid) chk(8, SMP_W'({s_axi_rresp, s_axi_rdata}));
		if (s_axi_bvalid) chk(9, SMP_W'(s_axi_bresp));
	end
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] r);
		logic aw;
		logic w;
		exp[9].push_back(SMP_W'(r));
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		aw = 1'b1;
		w = 1'b1;
		while (aw || w) begin
			@(posedge clk);
			if (aw && s_axi_awready) begin
				s_axi_awvalid <= 1'b0;
				aw = 1'b0;
			end
			if (w && s_axi_wready) begin
				s_axi_wvalid <= 1'b0;
				w = 1'b0;
			end
		end
		do @(posedge clk); while (!s_axi_bvalid);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] r);
		exp[8].push_back(SMP_W'({r, d}));
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk); while (!s_axi_rvalid);
	endtask
	task automatic setsrc(input int t, input logic [1:0] c);
		logic [11:0] a [4] = '{12'h030, 12'h034, 12'h038, 12'h078};
		src_m[t] = c;
		wr(a[t], t == 3 ? 32'(c) : 32'(c) << 7, RESP_OKAY);
	endtask
	// s: 0 S/PDIF receive, 1 ADC, 2 secondary, 3 all converter inputs
	task automatic send(input logic [1:0] s, input logic drop);
		logic [SMP_W-1:0] w;
		logic [SMP_W-1:0] v;
		logic ok;
		w = SMP_W'({$urandom, $urandom});
		v = s == 2'h3 ? w ^ SMP_W'(map_m[1:0]) : w;
		ok = s != 2'h3 || map_m[1:0] != 2'h3;
		if (ok && src_m[0] == s && s != 2'h1) exp[0].push_back(v);
		for (int i = 1; i < 3; i++)
			if (s == 2'h3 && (src_m[0] != 2'h0 || map_m[8]) &&
				map_m[2*i+:2] != 2'h3)
				exp[i].push_back(w ^ SMP_W'(map_m[2*i+:2]));
		if (src_m[1] == s && s != 2'h3) exp[3].push_back(w);
		if (ok && src_m[2] == s && s != 2'h2) exp[4].push_back(v);
		if (ok && src_m[3] == s && !drop) exp[5].push_back(v);
		fire <= s == 2'h3 ? 6'h38 : 6'h01 << s;
		word <= w;
		@(posedge clk);
		fire <= '0;
		repeat (2) @(posedge clk);
	endtask
	logic [11:0] ra [8] = '{12'h018, 12'h020, 12'h030, 12'h034, 12'h038,
		12'h078, 12'h080, 12'h3FC};
	logic [31:0] rv [8] = '{32'h0, 32'h0, 32'h180, 32'h80, 32'h0, 32'h0,
		32'h24, 32'h0};
	logic [8:0] maps [3] = '{9'h024, 9'h112, 9'h037};
	initial begin
		logic au;
		logic [1:0] dc;
		logic [1:0] ac;
		logic [31:0] b;
		void'($urandom(59));
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 8; i++)
			rd(ra[i], rv[i], i == 7 ? RESP_SLVERR : RESP_OKAY);
		wr(12'h030, 32'hFFFFFFFF, RESP_OKAY);
		rd(12'h030, 32'h180, RESP_OKAY);
		wr(12'h3FC, 32'h1, RESP_SLVERR);
		$display("register test done");
		for (int p = 0; p < 3; p++) begin
			map_m = maps[p];
			wr(12'h080, 32'(map_m), RESP_OKAY);
			for (int t = 0; t < 4; t++)
				for (int c = 0; c < 4; c++) begin
					setsrc(t, 2'(c));
					for (int s = 0; s < 4; s++)
						send(2'(s), 1'b0);
				end
		end
		$display("routing test done");
		setsrc(3, 2'h0);
		stall <= 1'b1;
		repeat (3) @(posedge clk);
		for (int k = 0; k < 3; k++)
			send(2'h0, k == 2);
		stall <= 1'b0;
		repeat (8) @(posedge clk);
		`CHK(exp[5].size(), 0)
		$display("buffer test done");
		for (int m = 0; m < 2; m++)
			for (int d = 0; d < 4; d += 3) begin
				wr(12'h018, 32'(m) << 6, RESP_OKAY);
				setsrc(0, 2'(d));
				for (int f = 0; f < 16; f++) begin
					au = m == 0 && d == 0;
					dc = f[1:0] == DACF_PLLA ? CLK_PLLA :
						f[1:0] == DACF_PLLB ? CLK_PLLB : CLK_MCLK;
					dc = au ? CLK_PLLA : dc;
					ac = au && f[3:2] == CLK_PLLA ? CLK_MCLK : f[3:2];
					wr(12'h020, 32'(f), RESP_OKAY);
					exp[7].push_back(SMP_W'({dc, ac}));
					repeat (2) @(posedge clk);
					probe[1] <= 1'b1;
					@(posedge clk);
					probe[1] <= 1'b0;
				end
			end
		$display("clock test done");
		for (int k = 0; k < 16; k++) begin
			if (k % 8 == 0)
				wr(12'h078, k == 0 ? 32'h8 : 32'h0, RESP_OKAY);
			b = $urandom;
			spdif_in_mux_bit <= b[0];
			spdif_tx_coded_bit <= b[1];
			exp[6].push_back(SMP_W'(k < 8 ? b[0] : b[1]));
			@(posedge clk);
			probe[0] <= 1'b1;
			@(posedge clk);
			probe[0] <= 1'b0;
		end
		repeat (4) @(posedge clk);
		for (int i = 0; i < 10; i++)
			`CHK(exp[i].size(), 0)
		$display("through test done");
		results();
	end
endmodule
bind asr_router asr_router_asserts u_asr_router_asserts (.clk, .rst_n,
	.s_axi_rvalid, .s_axi_arready, .adc_data, .adc_valid, .spdif_rx_valid,
	.sec_rx_valid, .converter_serial_valid, .dac_data, .dac_valid,
	.dac_enable, .pri_tx_data, .pri_tx_valid, .spdif_tx_data,
	.spdif_tx_valid, .spdif_tx_ready, .spdif_payload_src_ready,
	.dac_clk_src);
